//--- design/pvd_defines.vh
// Register map, field positions and reset values of the VCO divider control block.
`ifndef PVD_DEFINES_VH
`define PVD_DEFINES_VH

// Register indices; the APB byte address is four times the index.
`define PVD_IDX_CONTROL 12'h120
`define PVD_IDX_RATIOS 12'h121
`define PVD_IDX_MASKS 12'h122
`define PVD_IDX_STATUS 12'h123

// Byte addresses on APB.
`define PVD_ADDR_CONTROL 12'h480
`define PVD_ADDR_RATIOS 12'h484
`define PVD_ADDR_MASKS 12'h488
`define PVD_ADDR_STATUS 12'h48C

// Control register fields.
`define PVD_CTL_A_RESET 0
`define PVD_CTL_A_PDOWN 1
`define PVD_CTL_A_SYNC 2
`define PVD_CTL_B_RESET 4
`define PVD_CTL_B_PDOWN 5
`define PVD_CTL_B_SYNC 6

// Mask register fields.
`define PVD_MSK_A_FIRST 0
`define PVD_MSK_B_DIV1 5
`define PVD_MSK_B_DIV2 6

// Writable bits; reserved bits read zero.
`define PVD_CTL_WMASK 8'h77
`define PVD_RAT_WMASK 8'hFF
`define PVD_MSK_WMASK 8'h7F

// Reset values.
`define PVD_CTL_RESET 8'h20
`define PVD_RAT_RESET 8'h44
`define PVD_MSK_RESET 8'h00

// Valid ratio code range.
`define PVD_RATIO_MIN 4'h2
`define PVD_RATIO_MAX 4'hB

`endif

//--- design/pvd_vco_divider_control.v
// VCO post-divider control: APB registers, two dividers and downstream sync holds.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pvd_defines.vh"

// What this block does
// [RULE1] Control bit 6 syncs dividers fed by B
// [RULE2] Control bit 2 syncs dividers fed by A
// [RULE3] Sync bit high holds dividers in reset
// [RULE4] Bits 4 and 0 reset dividers B, A
// [RULE5] Bits 5, 1 power down; B starts down
// [RULE6] Ratio upper nibble sets divider B, reset 4
// [RULE7] Ratio lower nibble sets divider A, reset 4
// [RULE8] Codes 2 to 11 divide; others power down
// [RULE9] Mask bits 0-4 ignore sync from A
// [RULE10] Mask bits 5-6 ignore sync from B
// [RULE11] Reserved bits read zero, ignore writes

module pvd_vco_divider_control (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // APB answer
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Divided VCO clocks, bit 0 divider A, bit 1 divider B
    output wire [1:0] vco_div_out,
    // Sync holds for output dividers 0 to 3
    output reg [3:0] output_divider_hold,
    // Sync hold for the fixed-delay feedback divider
    output reg fixed_delay_feedback_divider_hold
);

    // Register storage and next values.
    reg [7:0] control_q;
    reg [7:0] control_d;
    reg [7:0] ratios_q;
    reg [7:0] ratios_d;
    reg [7:0] masks_q;
    reg [7:0] masks_d;

    // Bus decode and the next values of the registered answer.
    wire setup;
    wire access;
    wire wr_en;
    wire sel_control;
    wire sel_ratios;
    wire sel_masks;
    wire wr_control;
    wire wr_ratios;
    wire wr_masks;
    reg hit_d;
    reg [7:0] rdata_d;
    reg pready_d;
    reg pslverr_d;
    reg [31:0] prdata_d;

    // Decoded control fields, index 0 for divider A and index 1 for divider B.
    wire [1:0] div_reset;
    wire [1:0] div_pdown;
    wire [7:0] div_ratio;
    wire [1:0] div_active;
    wire [1:0] div_cnt_zero;
    wire [7:0] status_word;

    // Sync routing to the five downstream dividers; B feeds only output dividers 1 and 2.
    localparam [4:0] FED_BY_B = 5'h06;
    wire sync_a;
    wire sync_b;
    wire [4:0] ignore_a;
    wire [4:0] ignore_b;
    wire [4:0] hold_d;

    // Setup is refused while an answer stands, so one request is answered exactly once.
    assign setup = psel & ~penable & ~pready;
    assign access = psel & penable & pready;
    assign wr_en = access & pwrite;

    // Address matches for the write path.
    assign sel_control = (paddr == `PVD_ADDR_CONTROL);
    assign sel_ratios = (paddr == `PVD_ADDR_RATIOS);
    assign sel_masks = (paddr == `PVD_ADDR_MASKS);
    assign wr_control = wr_en & sel_control;
    assign wr_ratios = wr_en & sel_ratios;
    assign wr_masks = wr_en & sel_masks;

    // Field decode of the control and ratio registers.
    assign div_reset = {control_q[`PVD_CTL_B_RESET], control_q[`PVD_CTL_A_RESET]}; // [RULE4]
    assign div_pdown = {control_q[`PVD_CTL_B_PDOWN], control_q[`PVD_CTL_A_PDOWN]}; // [RULE5]
    assign div_ratio = ratios_q; // [RULE6] [RULE7]

    // Status: bit 0 A active, bit 1 B active, bits 2 and 3 counters at zero.
    assign status_word = {4'h0, div_cnt_zero, div_active};

    // Address decode for reads; reserved bits are never stored, so they read zero.
    always @*
    begin
        hit_d = 1'h1;
        rdata_d = 8'h00;
        case (paddr)
            `PVD_ADDR_CONTROL: rdata_d = control_q; // [RULE11]
            `PVD_ADDR_RATIOS: rdata_d = ratios_q;
            `PVD_ADDR_MASKS: rdata_d = masks_q; // [RULE11]
            `PVD_ADDR_STATUS: rdata_d = status_word;
            default: hit_d = 1'h0;
        endcase
    end

    // The answer is prepared in the setup cycle and shown in the access cycle.
    always @*
    begin
        pready_d = setup;
        pslverr_d = pslverr;
        prdata_d = prdata;
        if (setup)
        begin
            pslverr_d = ~hit_d;
            if (pwrite)
                prdata_d = 32'h00000000;
            else
                prdata_d = {24'h000000, rdata_d};
        end
        else if (access)
        begin
            pslverr_d = 1'h0;
            prdata_d = 32'h00000000;
        end
    end

    // No wait state on any transfer; a fixed latency keeps the bus side simple.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'h0;
        end
        else
        begin
            pready <= pready_d;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'h0;
        end
        else
        begin
            pslverr <= pslverr_d;
        end
    end

    // Read data is cleared after each access so a stale value is never shown.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else
        begin
            prdata <= prdata_d;
        end
    end

    // Writes take effect only at the completing access edge; write masks drop reserved bits.
    always @*
    begin
        control_d = control_q;
        ratios_d = ratios_q;
        masks_d = masks_q;
        if (wr_control)
            control_d = pwdata[7:0] & `PVD_CTL_WMASK; // [RULE11]
        if (wr_ratios)
            ratios_d = pwdata[7:0] & `PVD_RAT_WMASK; // [RULE6] [RULE7]
        if (wr_masks)
            masks_d = pwdata[7:0] & `PVD_MSK_WMASK; // [RULE11]
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_q <= `PVD_CTL_RESET; // [RULE5]
        end
        else
        begin
            control_q <= control_d;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ratios_q <= `PVD_RAT_RESET; // [RULE6] [RULE7]
        end
        else
        begin
            ratios_q <= ratios_d;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            masks_q <= `PVD_MSK_RESET;
        end
        else
        begin
            masks_q <= masks_d;
        end
    end

    // The two dividers run on pclk, which stands in for the VCO clock here.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_div
            wire [3:0] ratio;
            wire ratio_ok;
            wire wrap;
            reg [3:0] cnt_q;
            reg [3:0] cnt_d;
            reg out_q;
            reg out_d;

            assign ratio = div_ratio[4*g+3:4*g]; // [RULE6] [RULE7]
            // An out-of-range code powers the divider down like the power-down bit.
            assign ratio_ok = (ratio >= `PVD_RATIO_MIN)
                & (ratio <= `PVD_RATIO_MAX); // [RULE8]
            assign div_active[g] = ~div_pdown[g] & ~div_reset[g] // [RULE4] [RULE5]
                & ratio_ok; // [RULE8]
            assign wrap = (cnt_q >= ratio - 4'h1);
            assign div_cnt_zero[g] = (cnt_q == 4'h0);
            assign vco_div_out[g] = out_q;

            // Reset and power-down both park the counter so a restart is phase aligned.
            always @*
            begin
                cnt_d = 4'h0;
                out_d = 1'h0;
                if (div_active[g])
                begin
                    if (wrap)
                        cnt_d = 4'h0;
                    else
                        cnt_d = cnt_q + 4'h1;
                    // High for the first half of each period; odd ratios run short-high.
                    out_d = (cnt_q < {1'h0, ratio[3:1]});
                end
            end

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt_q <= 4'h0;
                end
                else
                begin
                    cnt_q <= cnt_d;
                end
            end

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    out_q <= 1'h0;
                end
                else
                begin
                    out_q <= out_d;
                end
            end
        end
    endgenerate

    // Sync routing: A reaches every downstream divider, B only output dividers 1 and 2.
    assign sync_a = control_q[`PVD_CTL_A_SYNC]; // [RULE2]
    assign sync_b = control_q[`PVD_CTL_B_SYNC]; // [RULE1]
    assign ignore_a = masks_q[4:0]; // [RULE9]
    assign ignore_b = {2'h0, masks_q[`PVD_MSK_B_DIV2], masks_q[`PVD_MSK_B_DIV1], 1'h0}; // [RULE10]

    genvar h;
    generate
        for (h = 0; h < 5; h = h + 1)
        begin : gen_hold
            wire from_a;
            wire from_b;

            assign from_a = sync_a & ~ignore_a[h]; // [RULE2] [RULE9]
            assign from_b = sync_b & FED_BY_B[h] & ~ignore_b[h]; // [RULE1] [RULE10]
            // Either unmasked sync holds the divider; the hold is a level, not a pulse.
            assign hold_d[h] = from_a | from_b; // [RULE3]
        end
    endgenerate

    // The holds cost one cycle of latency so that each output comes from a flip-flop.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_divider_hold <= 4'h0;
        end
        else
        begin
            output_divider_hold <= hold_d[3:0]; // [RULE3]
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fixed_delay_feedback_divider_hold <= 1'h0;
        end
        else
        begin
            fixed_delay_feedback_divider_hold <= hold_d[4]; // [RULE9]
        end
    end

endmodule
`default_nettype wire

//--- tb/pvd_vco_divider_control_asserts.sv
// Port-level checks for the VCO divider control block.
`timescale 1ns/1ps
`default_nettype none
`include "pvd_defines.vh"
module pvd_chk (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [1:0] vco_div_out,
    input wire logic [3:0] output_divider_hold,
    input wire logic fixed_delay_feedback_divider_hold
);
    wire done = psel & penable & pready & pwrite;
    wire wc = done && paddr == `PVD_ADDR_CONTROL;
    wire wr = done && paddr == `PVD_ADDR_RATIOS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_idle_data: assert property (!pready |-> prdata == 0) else $error("stray data");
    a_rsvd_zero: assert property (
        pready && !pwrite && paddr == `PVD_ADDR_CONTROL |-> (prdata & ~32'h77) == 0)
        else $error("reserved bit set");
    a_no_sync: assert property (
        wc && !pwdata[2] && !pwdata[6] |-> ##2 !output_divider_hold
        && !fixed_delay_feedback_divider_hold) else $error("hold without sync");
    a_a_reset: assert property (wc && pwdata[0] |-> ##2 !vco_div_out[0] [*2])
        else $error("divider a runs in reset");
    a_b_down: assert property (wc && pwdata[5] |-> ##2 !vco_div_out[1] [*2])
        else $error("divider b runs powered down");
    a_a_badratio: assert property (
        wr && (pwdata[3:0] < 2 || pwdata[3:0] > 11) |-> ##2 !vco_div_out[0] [*2])
        else $error("divider a runs on bad ratio");
endmodule
bind pvd_vco_divider_control pvd_chk u_chk (.*);
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the VCO divider control block.
`timescale 1ns/1ps
`default_nettype none
`include "pvd_defines.vh"
`define CHK(a,e) begin tests_run++; if ((a)!==(e)) begin mismatches++; \
 $display("[FAIL] %0t %h %h",$time,a,e); end end
module tb_top;
    logic pclk=0, presetn=0, psel=0, penable=0, pwrite=0;
    logic [11:0] paddr=0;
    logic [31:0] pwdata=0, prdata, q;
    logic pready, pslverr, e, fixed_delay_feedback_divider_hold;
    logic [1:0] vco_div_out;
    logic [3:0] output_divider_hold;
    int mismatches=0, tests_run=0, cyc=0, n[2];
    logic [3:0] ca[5]='{2,11,12,0,3}, cb[5]='{11,3,2,15,1};
    pvd_vco_divider_control uut (.*);
    initial forever #25 pclk=~pclk;
    task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel<=1; pwrite<=w; paddr<=a; pwdata<=d;
        @(posedge pclk);
        penable<=1;
        do @(posedge pclk); while (pready!==1'b1);
        q=prdata; e=pslverr;
        psel<=0; penable<=0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        rw(0,a,0);
        `CHK(q,x)
    endtask
    task automatic hd(input logic [4:0] x);
        repeat (3) @(posedge pclk);
        `CHK({fixed_delay_feedback_divider_hold,output_divider_hold},x)
    endtask
    // A window of 132 cycles holds whole periods of ratio codes 2, 3, 4 and 11.
    task automatic cc(input int ea, input int eb);
        n='{0,0};
        repeat (132) @(posedge pclk) for (int i=0;i<2;i++) n[i]+=(vco_div_out[i]===1'b1);
        `CHK(n[0],ea)
        `CHK(n[1],eb)
    endtask
    function automatic int eh(input logic [3:0] r);
        return (r>=2 && r<=11) ? (r/2)*(132/r) : 0;
    endfunction
    task automatic report_and_stop;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches==0 && tests_run>0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc==9000)
        begin
            mismatches++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn<=1;
        rd(`PVD_ADDR_CONTROL,32'h20);
        rd(`PVD_ADDR_RATIOS,32'h44);
        rd(`PVD_ADDR_MASKS,0);
        cc(66,0);
        rw(1,`PVD_ADDR_CONTROL,32'hFF);
        rd(`PVD_ADDR_CONTROL,32'h77);
        hd(5'h1F);
        cc(0,0);
        rw(1,`PVD_ADDR_MASKS,32'hFF);
        rd(`PVD_ADDR_MASKS,32'h7F);
        hd(0);
        rw(1,`PVD_ADDR_MASKS,32'h1F);
        hd(5'h06);
        rw(1,`PVD_ADDR_CONTROL,32'h40);
        rw(1,`PVD_ADDR_MASKS,32'h20);
        hd(5'h04);
        rw(1,`PVD_ADDR_CONTROL,32'h04);
        rw(1,`PVD_ADDR_MASKS,32'h0A);
        hd(5'h15);
        rw(1,`PVD_ADDR_CONTROL,32'h11);
        rd(`PVD_ADDR_STATUS,32'h0C);
        cc(0,0);
        rw(1,`PVD_ADDR_CONTROL,32'h22);
        cc(0,0);
        rw(1,`PVD_ADDR_CONTROL,0);
        hd(0);
        foreach (ca[i])
        begin
            rw(1,`PVD_ADDR_RATIOS,{24'h0,cb[i],ca[i]});
            rd(`PVD_ADDR_RATIOS,{24'h0,cb[i],ca[i]});
            repeat (12) @(posedge pclk);
            cc(eh(ca[i]),eh(cb[i]));
        end
        rd(12'h4A0,0);
        `CHK(e,1'b1)
        report_and_stop;
    end
endmodule
`default_nettype wire
